// ===== hw/cats_pkg.sv
/*
 Package for the counter array software-timer compare module: mode bit
 positions, reset values and widths.
 Assumes a single 125 MHz system clock shared by all users.
*/
`default_nettype none
package cats_pkg;
    localparam int COUNT_WIDTH = 16;
    localparam int BYTE_WIDTH = 8;
    localparam int CAPTURE_HOLD_CYCLES = 2;
    // Mode register layout, coined bit positions
    localparam int MODE_MATCH_ENABLE_BIT = 3;
    localparam int MODE_INT_ENABLE_BIT = 0;
    localparam int MODE_COMPARE_ENABLE_BIT = 6;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [15:0] COMPARE_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    typedef enum logic [1:0] {
        CATS_IDLE,
        CATS_ARMED,
        CATS_MATCHED
    } cats_state_type;
endpackage : cats_pkg
`default_nettype wire

// ===== hw/cats_capture_sync.sv
/*
 Capture pin level filter: a new level is accepted once it has stood
 for the given number of clock cycles.
 Assumes the pin is already synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cats_capture_sync #(
    parameter int HOLD = cats_pkg::CAPTURE_HOLD_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Pin and filtered level
    input wire logic pinIn,
    output logic level
);
    logic [3:0] stable;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stable <= 4'h0;
            level <= 1'b0;
        end else if (pinIn == level) begin
            stable <= 4'h0;
        end else if (stable >= 4'(HOLD - 1)) begin
            stable <= 4'h0;
            level <= pinIn;
        end else begin
            stable <= stable + 4'h1;
        end
    end
endmodule : cats_capture_sync
`default_nettype wire

// ===== hw/cats_soft_timer.sv
/*
 One counter array module in software-timer (compare) mode.
 Assumes the shared counter and its increment pulse come from outside,
 and software byte writes arrive as one-cycle strobes with data.
*/
// How it works
// - Compare shared counter with full 16-bit value
// - Match sets module match flag to one
// - Interrupt request only when flag interrupt enabled
// - Flag stays set until software clears it
// - Timer mode needs compare and match enables
// - Low byte write clears compare enable
// - High byte write sets compare enable
`timescale 1ns/1ps
`default_nettype none
module cats_soft_timer #(
    parameter int WIDTH = cats_pkg::COUNT_WIDTH
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Shared counter
    input wire logic [WIDTH-1:0] counterValue,
    input wire logic counterTick,
    // Mode register access
    input wire logic modeWrite,
    input wire logic [7:0] modeData,
    output logic [7:0] moduleModeReg,
    // Compare value access
    input wire logic lowWrite,
    input wire logic highWrite,
    input wire logic [7:0] byteData,
    output logic [WIDTH-1:0] compareValue,
    // Flag in the array control register
    input wire logic flagClear,
    output logic moduleMatchFlag,
    output logic interruptRequest,
    // Capture pin and status
    input wire logic moduleCapturePin,
    output logic captureLevel,
    output logic timerActive
);
    cats_pkg::cats_state_type state;
    logic compareEnableBit;
    logic matchFlagEnableBit;
    logic matchHit;

    function automatic logic bitOf(input logic [7:0] r, input int pos);
        bitOf = r[pos];
    endfunction : bitOf

    assign compareEnableBit = bitOf(moduleModeReg, cats_pkg::MODE_COMPARE_ENABLE_BIT);
    assign matchFlagEnableBit = bitOf(moduleModeReg, cats_pkg::MODE_MATCH_ENABLE_BIT);
    assign timerActive = compareEnableBit && matchFlagEnableBit;
    // Counter already advanced: compare once per tick only
    assign matchHit = timerActive && counterTick && (counterValue == compareValue);

    // Mode register; byte writes override the compare enable bit
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            moduleModeReg <= cats_pkg::MODE_RESET;
        end else begin
            if (modeWrite) begin
                moduleModeReg <= modeData;
            end
            if (lowWrite) begin
                moduleModeReg[cats_pkg::MODE_COMPARE_ENABLE_BIT] <= 1'b0;
            end else if (highWrite) begin
                moduleModeReg[cats_pkg::MODE_COMPARE_ENABLE_BIT] <= 1'b1;
            end
        end
    end

    // Compare value bytes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            compareValue <= cats_pkg::COMPARE_RESET;
        end else begin
            if (lowWrite) begin
                compareValue[cats_pkg::BYTE_WIDTH-1:0] <= byteData;
            end
            if (highWrite) begin
                compareValue[WIDTH-1:cats_pkg::BYTE_WIDTH] <= byteData;
            end
        end
    end

    // Flag: set wins over a clear in the same cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            moduleMatchFlag <= 1'b0;
        end else if (matchHit) begin
            moduleMatchFlag <= 1'b1;
        end else if (flagClear) begin
            moduleMatchFlag <= 1'b0;
        end
    end

    // Tracking state for observation
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= cats_pkg::CATS_IDLE;
        end else begin
            case (state)
                cats_pkg::CATS_IDLE: begin
                    if (timerActive) state <= cats_pkg::CATS_ARMED;
                end
                cats_pkg::CATS_ARMED: begin
                    if (!timerActive) state <= cats_pkg::CATS_IDLE;
                    else if (matchHit) state <= cats_pkg::CATS_MATCHED;
                end
                cats_pkg::CATS_MATCHED: begin
                    if (!timerActive) state <= cats_pkg::CATS_IDLE;
                    else if (counterTick) state <= cats_pkg::CATS_ARMED;
                end
                default: state <= cats_pkg::CATS_IDLE;
            endcase
        end
    end

    // Request follows the sticky flag; no auto clear on vectoring
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            interruptRequest <= 1'b0;
        end else begin
            interruptRequest <= (moduleMatchFlag || matchHit)
                && bitOf(moduleModeReg, cats_pkg::MODE_INT_ENABLE_BIT)
                && !(flagClear && !matchHit);
        end
    end

    cats_capture_sync #(
        .HOLD(cats_pkg::CAPTURE_HOLD_CYCLES)
    ) u_capture (
        .clock(clock),
        .reset_n(reset_n),
        .pinIn(moduleCapturePin),
        .level(captureLevel)
    );
endmodule : cats_soft_timer
`default_nettype wire

// ===== tb/cats_soft_timer_properties.sv
/* Assertions on the ports of cats_soft_timer.
 Assumes one clock domain; bound to every instance below. */
`timescale 1ns/1ps
`default_nettype none
module cats_soft_timer_properties #(parameter int WIDTH = 16) (
    // Clock, reset, counter
    input wire logic clock, reset_n, counterTick,
    input wire logic [WIDTH-1:0] counterValue, compareValue,
    // Writes and pin
    input wire logic modeWrite, lowWrite, highWrite, flagClear, moduleCapturePin,
    input wire logic [7:0] modeData, byteData, moduleModeReg,
    // Status
    input wire logic moduleMatchFlag, interruptRequest, captureLevel, timerActive
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    wire logic hit = counterTick && timerActive && counterValue == compareValue;
    match_sets_flag_a: assert property (hit |=> moduleMatchFlag)
        else $error("match did not set flag");
    irq_needs_en_a: assert property (interruptRequest |-> $past(moduleModeReg[0]))
        else $error("request without enable");
    irq_follows_a: assert property (moduleMatchFlag && moduleModeReg[0] && !flagClear
        && !modeWrite |=> interruptRequest) else $error("enabled flag gave no request");
    flag_sticky_a: assert property (moduleMatchFlag && !flagClear |=> moduleMatchFlag)
        else $error("flag dropped by itself");
    timer_mode_a: assert property (timerActive == (moduleModeReg[6] && moduleModeReg[3]))
        else $error("timer mode decode wrong");
    low_clears_a: assert property (lowWrite |=> !moduleModeReg[6]
        && compareValue[7:0] == $past(byteData)) else $error("low write wrong");
    high_sets_a: assert property (highWrite && !lowWrite |=> moduleModeReg[6]
        && compareValue[15:8] == $past(byteData)) else $error("high write wrong");
    no_false_match_a: assert property (!hit && !moduleMatchFlag |=> !moduleMatchFlag)
        else $error("flag set without match");
endmodule : cats_soft_timer_properties
bind cats_soft_timer cats_soft_timer_properties #(.WIDTH(WIDTH)) cats_props_i (.*);
`default_nettype wire

// ===== tb/tb.sv
/* Self-checking bench for cats_soft_timer.
 Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock = 1'b0, reset_n = 1'b0, counterTick = 1'b0, modeWrite = 1'b0;
    logic lowWrite = 1'b0, highWrite = 1'b0, flagClear = 1'b0, moduleCapturePin = 1'b0;
    logic [15:0] counterValue = 16'h0000;
    logic [7:0] modeData = 8'h00, byteData = 8'h00;
    logic [7:0] moduleModeReg;
    logic [15:0] compareValue;
    logic moduleMatchFlag, interruptRequest, captureLevel, timerActive;
    int mismatches = 0;
    int samples_checked = 0;
    cats_soft_timer cats_soft_timer_i (.*);
    initial forever #4 clock = ~clock;
    // One strobe per call: 0 mode, 1 low, 2 high, 3 clear, 4 tick
    task automatic op(input int k, input logic [15:0] v);
        @(posedge clock);
        modeWrite <= (k == 0);
        lowWrite <= (k == 1);
        highWrite <= (k == 2);
        flagClear <= (k == 3);
        counterTick <= (k == 4);
        modeData <= v[7:0];
        byteData <= v[7:0];
        counterValue <= v;
        @(posedge clock);
        {modeWrite, lowWrite, highWrite, flagClear, counterTick} <= 5'h00;
        #1;
    endtask : op
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    // Watchdog in case the sequence hangs
    initial begin
        #100000;
        mismatches++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        #1 chk(compareValue, 16'h0000);
        op(0, 16'h0009);
        chk(timerActive, 1'b0);
        op(1, 16'h0034);
        chk({compareValue[7:0], moduleModeReg}, 16'h3409);
        op(2, 16'h0012);
        chk(compareValue, 16'h1234);
        chk({timerActive, moduleModeReg}, 16'h0149);
        $display("test compare load done");
        op(4, 16'h0034);
        chk(moduleMatchFlag, 1'b0);
        op(4, 16'h1234);
        chk({moduleMatchFlag, interruptRequest}, 16'h0003);
        op(0, 16'h0048);
        chk(moduleMatchFlag, 1'b1);
        op(3, 16'h0000);
        chk({moduleMatchFlag, interruptRequest}, 16'h0000);
        op(4, 16'h1234);
        chk({moduleMatchFlag, interruptRequest}, 16'h0002);
        op(3, 16'h0000);
        op(1, 16'h0034);
        chk(moduleModeReg, 8'h08);
        op(4, 16'h1234);
        chk(moduleMatchFlag, 1'b0);
        $display("test match flag done");
        // A one-cycle glitch must not pass the filter
        @(posedge clock) moduleCapturePin <= 1'b1;
        @(posedge clock) moduleCapturePin <= 1'b0;
        repeat (3) @(posedge clock);
        #1 chk(captureLevel, 1'b0);
        @(posedge clock) moduleCapturePin <= 1'b1;
        repeat (2) @(posedge clock);
        #1 chk(captureLevel, 1'b1);
        $display("test capture pin done");
        conclude();
    end
endmodule : tb
`default_nettype wire
